/* File: src/fcf_regs.svh */
// Register map, field positions, reset values and timing counts of the
// fully-closed feedback block. Definitions only; included by the top.
`ifndef FCF_REGS_SVH
`define FCF_REGS_SVH
`define FCF_OFF_CTRL      12'h000
`define FCF_OFF_PITCH     12'h004
`define FCF_OFF_RES       12'h008
`define FCF_OFF_ERRLVL    12'h00c
`define FCF_OFF_STATUS    12'h010
`define FCF_OFF_MASK      12'h014
`define FCF_OFF_FBCOUNT   12'h018
`define FCF_OFF_ACTIVE    12'h01c
`define FCF_CTRL_DIR      0
`define FCF_CTRL_USE_LSB  4
`define FCF_CTRL_RESTART  8
`define FCF_ST_OVERSPEED  0
`define FCF_ST_DEVIATION  1
`define FCF_ST_CFGERR     2
`define FCF_RST_DIR       1'h0
`define FCF_RST_USAGE     3'h0
`define FCF_RST_PITCH     21'h008000
`define FCF_MIN_PITCH     21'h000004
`define FCF_MAX_PITCH     21'h100000
`define FCF_RST_RES       13'h0014
`define FCF_MIN_RES       13'h0001
`define FCF_MAX_RES       13'h1000
`define FCF_RST_ERRLVL    31'h000003e8
`define FCF_EXT_EDGES     13'h1000
`define FCF_CLK_NS        10
`define FCF_OVS_WIN_NS    10000
`define FCF_OVS_KPPS      6400
`define FCF_OVS_WIN_CYC   (`FCF_OVS_WIN_NS / `FCF_CLK_NS)
`define FCF_OVS_MAX_EDGES (`FCF_OVS_KPPS * `FCF_OVS_WIN_NS / 1000000)
`endif

/* File: src/fcf_pkg.sv */
// Types shared by the fully-closed feedback block.
// Assumes the constants of fcf_regs.svh for widths of the fields.
package fcf_pkg;
    typedef enum logic [2:0] {
        FCF_USE_NONE = 3'h0,
        FCF_USE_FWD  = 3'h1,
        FCF_USE_RSV2 = 3'h2,
        FCF_USE_REV  = 3'h3,
        FCF_USE_RSV4 = 3'h4
    } fcf_usage_t;

    typedef struct packed {
        logic        dir_sel;
        fcf_usage_t  usage;
        logic [20:0] pitches;
        logic [12:0] res;
    } fcf_cfg_t;

    typedef struct packed {
        logic a;
        logic b;
    } fcf_quad_t;
endpackage : fcf_pkg

/* File: src/fcf_top.sv */
// Fully-closed position feedback: load encoder counting, divided A/B/Z
// re-output, overspeed and motor-load deviation alarms, APB registers.
// Assumes all inputs synchronous to clk_i and a zero-wait APB master.
//
// Behaviour
// - Usage 1 counts load encoder up for CCW; usage 3 inverts count sense.
// - Usage 0 disables the load encoder; 2 and 4 reserved; applies at restart.
// - Direction select 0 gives CCW for forward reference, 1 gives CW.
// - Divided outputs have phase B leading phase A for forward movement.
// - Forward is the direction in which the feedback counter increments.
// - Scale pitches per revolution 4 to 1048576, default 32768, at restart.
// - Output resolution 1 to 4096 edges per pitch, default 20, at restart.
// - Raise overspeed alarm when divided edge rate exceeds 6.4 Mpps.
// - Resolution above the interpolated edges per pitch cannot be reproduced.
// - Alarm when motor-load difference exceeds level; level zero disables it. Code raises it only with usage 1 or 3.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "fcf_regs.svh"
`default_nettype none

module fcf_top
    import fcf_pkg::*;
(
    input  wire logic        clk_i,         // 100 MHz clock
    input  wire logic        nrst_i,        // Synchronous reset, active low
    input  wire logic        en_i,          // Clock enable, freezes all state
    input  wire logic        psel_i,        // APB select
    input  wire logic        penable_i,     // APB enable
    input  wire logic        pwrite_i,      // APB write
    input  wire logic [11:0] paddr_i,       // APB byte address
    input  wire logic [31:0] pwdata_i,      // APB write data
    output logic      [31:0] prdata_o,      // APB read data
    output logic             pready_o,      // APB ready
    output logic             pslverr_o,     // APB error, unmapped address
    input  wire fcf_quad_t   load_enc_i,    // Load encoder A/B
    input  wire logic [31:0] motor_pos_i,   // Motor position, ref units
    input  wire logic        ref_fwd_i,     // Forward reference active
    output logic             motor_ccw_o,   // Motor turns CCW
    output logic             divided_phase_a_out_o, // Divided phase A
    output logic             divided_phase_b_out_o, // Divided phase B
    output logic             divided_index_out_o,   // Divided index pulse
    output logic             irq_o          // Level interrupt
);
    fcf_cfg_t    pend;
    fcf_cfg_t    active;
    logic [30:0] err_level;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [31:0] fb_count;
    logic        restart_q;
    fcf_quad_t   enc_q;
    logic [12:0] acc;
    logic [1:0]  quad_idx;
    logic [12:0] in_pitch;
    logic [20:0] pitch_pos;
    logic [9:0]  win_cyc;
    logic [9:0]  win_edges;
    logic        ovs_hit;
    logic        dev_hit;
    logic        cfg_bad;
    fcf_cfg_t    next_active;

    wire logic wr_acc = psel_i & penable_i & pwrite_i & en_i;
    wire logic setup  = psel_i & ~penable_i & en_i;
    wire logic [2:0] st_w1c = (wr_acc && paddr_i == `FCF_OFF_STATUS)
                              ? pwdata_i[2:0] : 3'h0;

    // Quadrature decode: one valid edge is exactly one phase changing.
    wire logic a_chg  = enc_q.a ^ load_enc_i.a;
    wire logic b_chg  = enc_q.b ^ load_enc_i.b;
    wire logic edge_v = a_chg ^ b_chg;
    wire logic raw_up = enc_q.b ^ load_enc_i.a;
    wire logic cnt_on = (active.usage == FCF_USE_FWD) ||
                        (active.usage == FCF_USE_REV);
    wire logic step   = edge_v & cnt_on;
    wire logic cnt_up = raw_up ^ (active.usage == FCF_USE_REV);

    // Interpolation cannot exceed its own edges per pitch.
    wire logic [12:0] res_eff = (active.res > `FCF_EXT_EDGES)
                                ? `FCF_EXT_EDGES : active.res;
    wire logic [13:0] acc_up  = {1'b0, acc} + {1'b0, res_eff};
    wire logic [13:0] acc_dn  = {1'b0, acc} - {1'b0, res_eff};
    wire logic emit_fwd = step & cnt_up & (acc_up >= {1'b0, `FCF_EXT_EDGES});
    wire logic emit_rev = step & ~cnt_up & acc_dn[13];
    wire logic emit     = emit_fwd | emit_rev;

    wire logic [32:0] dev = {motor_pos_i[31], motor_pos_i} -
                            {fb_count[31], fb_count};
    wire logic [32:0] dev_abs = dev[32] ? (33'h0 - dev) : dev;

    // Validate the staged setting; bad fields fall back to defaults.
    always_comb begin
        next_active = pend;
        cfg_bad     = 1'b0;
        if (pend.usage != FCF_USE_NONE && pend.usage != FCF_USE_FWD &&
            pend.usage != FCF_USE_REV) begin
            next_active.usage = FCF_USE_NONE;
            cfg_bad           = 1'b1;
        end
        if (pend.pitches < `FCF_MIN_PITCH ||
            pend.pitches > `FCF_MAX_PITCH) begin
            next_active.pitches = `FCF_RST_PITCH;
            cfg_bad             = 1'b1;
        end
        if (pend.res < `FCF_MIN_RES || pend.res > `FCF_MAX_RES) begin
            next_active.res = `FCF_RST_RES;
            cfg_bad         = 1'b1;
        end
    end

    // Staged setting, written by software at any time.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pend      <= {`FCF_RST_DIR, FCF_USE_NONE, `FCF_RST_PITCH,
                          `FCF_RST_RES};
            err_level <= `FCF_RST_ERRLVL;
            mask      <= 3'h0;
            restart_q <= 1'b0;
        end else if (en_i) begin
            restart_q <= wr_acc && paddr_i == `FCF_OFF_CTRL &&
                         pwdata_i[`FCF_CTRL_RESTART];
            if (wr_acc) begin
                unique case (paddr_i)
                    `FCF_OFF_CTRL: begin
                        pend.dir_sel <= pwdata_i[`FCF_CTRL_DIR];
                        pend.usage   <= fcf_usage_t'(
                            pwdata_i[`FCF_CTRL_USE_LSB +: 3]);
                    end
                    `FCF_OFF_PITCH:  pend.pitches <= pwdata_i[20:0];
                    `FCF_OFF_RES:    pend.res     <= pwdata_i[12:0];
                    `FCF_OFF_ERRLVL: err_level    <= pwdata_i[30:0];
                    `FCF_OFF_MASK:   mask         <= pwdata_i[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Working setting changes only at reset or on a restart command.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            active <= {`FCF_RST_DIR, FCF_USE_NONE, `FCF_RST_PITCH,
                       `FCF_RST_RES};
        end else if (en_i && restart_q) begin
            active <= next_active;
        end
    end

    // Feedback counter and divided pulse generation.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            enc_q    <= '0;
            fb_count <= 32'h0;
            acc      <= 13'h0;
            quad_idx <= 2'h0;
        end else if (en_i) begin
            enc_q <= load_enc_i;
            if (step) begin
                fb_count <= cnt_up ? fb_count + 32'h1
                                   : fb_count - 32'h1;
                if (cnt_up) begin
                    acc <= emit_fwd ? 13'(acc_up - {1'b0, `FCF_EXT_EDGES})
                                    : acc_up[12:0];
                end else begin
                    acc <= emit_rev ? 13'(acc_dn + {1'b0, `FCF_EXT_EDGES})
                                    : acc_dn[12:0];
                end
            end
            if (emit_fwd) begin
                quad_idx <= quad_idx + 2'h1;
            end else if (emit_rev) begin
                quad_idx <= quad_idx - 2'h1;
            end
        end
    end

    // Gray sequence 00,01,11,10 makes B lead A on a forward count.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            divided_phase_a_out_o <= 1'b0;
            divided_phase_b_out_o <= 1'b0;
        end else if (en_i) begin
            divided_phase_a_out_o <= quad_idx[1];
            divided_phase_b_out_o <= quad_idx[1] ^ quad_idx[0];
        end
    end

    // Index once per load revolution of counted scale pitches.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            in_pitch            <= 13'h0;
            pitch_pos           <= 21'h0;
            divided_index_out_o <= 1'b0;
        end else if (en_i) begin
            divided_index_out_o <= 1'b0;
            if (step && cnt_up) begin
                if (in_pitch == `FCF_EXT_EDGES - 13'h1) begin
                    in_pitch <= 13'h0;
                    if (pitch_pos == active.pitches - 21'h1) begin
                        pitch_pos           <= 21'h0;
                        divided_index_out_o <= 1'b1;
                    end else begin
                        pitch_pos <= pitch_pos + 21'h1;
                    end
                end else begin
                    in_pitch <= in_pitch + 13'h1;
                end
            end else if (step) begin
                if (in_pitch == 13'h0) begin
                    in_pitch <= `FCF_EXT_EDGES - 13'h1;
                    if (pitch_pos == 21'h0) begin
                        pitch_pos           <= active.pitches - 21'h1;
                        divided_index_out_o <= 1'b1;
                    end else begin
                        pitch_pos <= pitch_pos - 21'h1;
                    end
                end else begin
                    in_pitch <= in_pitch - 13'h1;
                end
            end
        end
    end

    // Edges are counted per fixed window; a finer window would flag
    // short bursts that the receiver absorbs anyway.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            win_cyc   <= 10'h0;
            win_edges <= 10'h0;
        end else if (en_i) begin
            if (win_cyc == 10'(`FCF_OVS_WIN_CYC - 1)) begin
                win_cyc   <= 10'h0;
                win_edges <= 10'h0;
            end else begin
                win_cyc   <= win_cyc + 10'h1;
                win_edges <= win_edges + {9'h0, emit};
            end
        end
    end

    assign ovs_hit = win_edges > 10'(`FCF_OVS_MAX_EDGES);
    assign dev_hit = (err_level != 31'h0) &&
                     (dev_abs > {2'h0, err_level});

    // Sticky alarms; a new event in the clearing cycle wins.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            status <= 3'h0;
        end else if (en_i) begin
            status[`FCF_ST_OVERSPEED] <= ovs_hit |
                (status[`FCF_ST_OVERSPEED] & ~st_w1c[`FCF_ST_OVERSPEED]);
            status[`FCF_ST_DEVIATION] <= (dev_hit & cnt_on) |
                (status[`FCF_ST_DEVIATION] & ~st_w1c[`FCF_ST_DEVIATION]);
            status[`FCF_ST_CFGERR] <= (restart_q & cfg_bad) |
                (status[`FCF_ST_CFGERR] & ~st_w1c[`FCF_ST_CFGERR]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            motor_ccw_o <= 1'b0;
        end else if (en_i) begin
            motor_ccw_o <= ref_fwd_i ^ active.dir_sel;
        end
    end

    // Read data is captured in the setup cycle and stands in the access.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            pslverr_o <= 1'b0;
            unique case (paddr_i)
                `FCF_OFF_CTRL:    prdata_o <= {25'h0, pend.usage,
                                               3'h0, pend.dir_sel};
                `FCF_OFF_PITCH:   prdata_o <= {11'h0, pend.pitches};
                `FCF_OFF_RES:     prdata_o <= {19'h0, pend.res};
                `FCF_OFF_ERRLVL:  prdata_o <= {1'b0, err_level};
                `FCF_OFF_STATUS:  prdata_o <= {29'h0, status};
                `FCF_OFF_MASK:    prdata_o <= {29'h0, mask};
                `FCF_OFF_FBCOUNT: prdata_o <= fb_count;
                `FCF_OFF_ACTIVE:  prdata_o <= {25'h0, active.usage,
                                               3'h0, active.dir_sel};
                default: begin
                    prdata_o  <= 32'h0;
                    pslverr_o <= 1'b1;
                end
            endcase
        end
    end

    assign pready_o = en_i;
    assign irq_o    = |(status & mask);

    a_fwd_usage_up: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && edge_v && active.usage == FCF_USE_FWD && raw_up
        |=> fb_count == $past(fb_count) + 32'h1)
        else $error("forward usage did not count up");
    a_rev_usage_dn: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && edge_v && active.usage == FCF_USE_REV && raw_up
        |=> fb_count == $past(fb_count) - 32'h1)
        else $error("reverse usage did not invert the count");
    a_off_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && active.usage == FCF_USE_NONE |=> $stable(fb_count))
        else $error("disabled encoder still counted");
    a_cfg_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(en_i && restart_q) |=> $stable(active))
        else $error("setting changed without restart");
    a_cfg_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
        active.pitches >= `FCF_MIN_PITCH && active.pitches <= `FCF_MAX_PITCH
        && active.res >= `FCF_MIN_RES && active.res <= `FCF_MAX_RES
        && active.usage != FCF_USE_RSV2 && active.usage != FCF_USE_RSV4)
        else $error("working setting out of range");
    a_motor_dir: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i ##1 en_i |-> motor_ccw_o ==
        ($past(ref_fwd_i) ^ $past(active.dir_sel)))
        else $error("motor direction wrong for reference");
    a_b_leads: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && emit_fwd ##1 en_i |=> (divided_phase_b_out_o !=
        $past(divided_phase_b_out_o)) == ($past(divided_phase_a_out_o, 2) ==
        $past(divided_phase_b_out_o, 2)))
        else $error("phase B does not lead on forward");
    a_res_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
        emit |-> step && res_eff <= `FCF_EXT_EDGES)
        else $error("divided edge without counted edge");
    a_ovs_alarm: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && win_edges > 10'(`FCF_OVS_MAX_EDGES)
        |=> status[`FCF_ST_OVERSPEED])
        else $error("overspeed alarm not raised");
    a_dev_alarm: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && cnt_on && err_level != 31'h0 &&
        dev_abs > {2'h0, err_level} |=> status[`FCF_ST_DEVIATION])
        else $error("deviation alarm not raised");
    a_dev_zero_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_i && err_level == 31'h0 && !status[`FCF_ST_DEVIATION]
        |=> !status[`FCF_ST_DEVIATION])
        else $error("deviation alarm with level zero");
endmodule : fcf_top

`default_nettype wire

/* File: test/fcf_enc_model.sv */
// Quadrature model of the load encoder that feeds the fully-closed block.
// Assumes the bench asks for one step per clock at most, on step_i.
`timescale 1ns/100ps
`default_nettype none

module fcf_enc_model
    import fcf_pkg::*;
(
    input  wire logic    clk_i,   // Bench clock
    input  wire logic    nrst_i,  // Synchronous reset, active low
    input  wire logic    step_i,  // Move one edge this cycle
    input  wire logic    up_i,    // Direction of the move
    output var fcf_quad_t enc_o   // Phases A and B
);
    logic [1:0] phase;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            phase <= 2'h0;
        end else if (step_i) begin
            phase <= up_i ? phase + 2'h1 : phase - 2'h1;
        end
    end

    // A Gray walk moves one phase per step; counting up, A leads B.
    // The encoder is always presented as incremental quadrature.
    always_comb begin
        case (phase)
            2'h0: enc_o = '{a: 1'b0, b: 1'b0};
            2'h1: enc_o = '{a: 1'b1, b: 1'b0};
            2'h2: enc_o = '{a: 1'b1, b: 1'b1};
            default: enc_o = '{a: 1'b0, b: 1'b1};
        endcase
    end
endmodule : fcf_enc_model

`default_nettype wire

/* File: test/fcf_top_bench.sv */
// Self-checking bench of the fully-closed feedback block and its encoder.
// Assumes a 100 MHz clock and zero-wait APB answers gated by en_i.
`timescale 1ns/100ps
`include "fcf_regs.svh"
`default_nettype none

module fcf_top_bench;
    import fcf_pkg::*;
    logic        clk_i, nrst_i, en_i, psel, penable, pwrite, ref_fwd;
    logic        step, up, pready_o, pslverr_o, motor_ccw_o, irq_o;
    logic        pa, pb, pidx;
    logic [11:0] paddr;
    logic [31:0] pwdata, motor_pos, prdata_o, lvl;
    logic [64:0] mon_e;
    logic [64:0] exp_q[$];
    fcf_quad_t   enc;
    int          err_total, n_compared, cycles, idx_seen, k, n;
    logic [31:0] rst_v [8] = '{0, 32'h8000, 32'h14, 32'h3e8, 0, 0, 0, 0};
    logic [11:0] bad_a [11] = '{0, 0, 0, 4, 4, 4, 4, 8, 8, 8, 8};
    logic [31:0] bad_d [11] = '{32'h120, 32'h140, 32'h150, 3, 4,
        32'h100000, 32'h100001, 0, 1, 32'h1000, 32'h1001};
    logic [2:0]  bad_s [11] = '{4, 4, 4, 4, 0, 0, 4, 4, 0, 0, 4};
    logic [1:0]  quad_f [4] = '{2'h1, 2'h3, 2'h2, 2'h0};

    fcf_top fcf_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .load_enc_i(enc),
        .motor_pos_i(motor_pos), .ref_fwd_i(ref_fwd),
        .motor_ccw_o(motor_ccw_o), .divided_phase_a_out_o(pa),
        .divided_phase_b_out_o(pb), .divided_index_out_o(pidx),
        .irq_o(irq_o));
    fcf_enc_model fcf_enc_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .step_i(step), .up_i(up), .enc_o(enc));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task results;
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail

    task chk(input logic [31:0] act, input logic [31:0] exp);
        n_compared++;
        if (act !== exp) fail("pin value");
    endtask : chk

    // The master holds every field until pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [64:0] e);
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {32'h0, 1'b0, 32'h0});
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] x, input logic er = 0);
        apb(1'b0, a, 32'h0, {32'hffffffff, er, x});
    endtask : rd

    task steps(input int cnt, input logic u, input int gap);
        repeat (cnt) begin
            @(posedge clk_i);
            step <= 1'b1; up <= u;
            @(posedge clk_i);
            step <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask : steps

    task settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    task do_reset;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask : do_reset

    // Compares each finished transfer with the oldest note.
    always @(posedge clk_i) begin
        if (psel && penable && pready_o === 1'b1) begin
            if (exp_q.size() == 0) fail("transfer without note");
            else begin
                mon_e = exp_q.pop_front();
                n_compared++;
                if (pslverr_o !== mon_e[32] || (prdata_o & mon_e[64:33])
                    !== (mon_e[31:0] & mon_e[64:33])) fail("apb answer");
            end
        end
        if (pidx === 1'b1) idx_seen++;
        cycles++;
        if (cycles == 80000) begin
            fail("timeout");
            results();
        end
    end

    initial begin
        nrst_i = 0; en_i = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; motor_pos = 0; ref_fwd = 0; step = 0; up = 0;
        err_total = 0; n_compared = 0; cycles = 0; idx_seen = 0;
        void'($urandom(32'h8394));
        do_reset();
        for (k = 0; k < 8; k++) rd(12'(k * 4), rst_v[k]);
        rd(12'h020, 32'h0, 1'b1);
        steps(3, 1'b1, 1);
        settle();
        rd(`FCF_OFF_FBCOUNT, 32'h0);
        wr(`FCF_OFF_CTRL, 32'h10);
        rd(`FCF_OFF_ACTIVE, 32'h0);
        @(posedge clk_i) ref_fwd <= 1'b1;
        settle();
        chk(motor_ccw_o, 1);
        wr(`FCF_OFF_CTRL, 32'h131);
        rd(`FCF_OFF_ACTIVE, 32'h31);
        settle();
        chk(motor_ccw_o, 0);
        @(posedge clk_i) ref_fwd <= 1'b0;
        settle();
        chk(motor_ccw_o, 1);
        // With the enable low the direction output must not follow.
        @(posedge clk_i) begin
            en_i    <= 1'b0;
            ref_fwd <= 1'b1;
        end
        settle();
        chk(motor_ccw_o, 1);
        @(posedge clk_i) en_i <= 1'b1;
        settle();
        chk(motor_ccw_o, 0);
        n = $urandom_range(9, 1);
        steps(n, 1'b1, 1);
        settle();
        rd(`FCF_OFF_FBCOUNT, -n);
        rd(`FCF_OFF_STATUS, 32'h0);
        for (k = 0; k < 11; k++) begin
            wr(bad_a[k], bad_d[k]);
            if (bad_a[k] != 0) wr(`FCF_OFF_CTRL, 32'h100);
            rd(`FCF_OFF_STATUS, bad_s[k]);
            rd(`FCF_OFF_ACTIVE, 32'h0);
            settle();
            chk(irq_o, 0);
            wr(`FCF_OFF_MASK, 32'h4);
            settle();
            chk(irq_o, bad_s[k][2]);
            wr(`FCF_OFF_STATUS, 32'h4);
            settle();
            chk(irq_o, 0);
            wr(`FCF_OFF_MASK, 32'h0);
            wr(`FCF_OFF_PITCH, 32'h8000);
            wr(`FCF_OFF_RES, 32'h14);
        end
        lvl = $urandom & 32'h7fffffff;
        wr(`FCF_OFF_ERRLVL, lvl);
        rd(`FCF_OFF_ERRLVL, lvl);
        // A second reset in mid-run clears the count for the index check.
        do_reset();
        idx_seen = 0;
        wr(`FCF_OFF_PITCH, 32'h4);
        wr(`FCF_OFF_RES, 32'h1000);
        wr(`FCF_OFF_CTRL, 32'h110);
        rd(`FCF_OFF_ACTIVE, 32'h10);
        for (k = 0; k < 4; k++) begin
            steps(1, 1'b1, 5);
            #1;
            chk({pa, pb}, quad_f[k]);
        end
        // One step back and forth walks the divided Gray code both ways.
        steps(1, 1'b0, 5);
        #1;
        chk({pa, pb}, quad_f[2]);
        steps(1, 1'b1, 5);
        #1;
        chk({pa, pb}, quad_f[3]);
        rd(`FCF_OFF_FBCOUNT, 32'h4);
        steps(16380, 1'b1, 0);
        settle();
        chk(idx_seen, 1);
        rd(`FCF_OFF_STATUS, 32'h3);
        repeat (1100) @(posedge clk_i);
        motor_pos <= 32'd16390;
        wr(`FCF_OFF_ERRLVL, 32'h0);
        wr(`FCF_OFF_STATUS, 32'h3);
        rd(`FCF_OFF_STATUS, 32'h0);
        wr(`FCF_OFF_ERRLVL, 32'h5);
        settle();
        rd(`FCF_OFF_STATUS, 32'h2);
        @(posedge clk_i) motor_pos <= 32'd16389;
        wr(`FCF_OFF_STATUS, 32'h2);
        rd(`FCF_OFF_STATUS, 32'h0);
        wr(`FCF_OFF_ERRLVL, 32'h0);
        steps(60, 1'b1, 15);
        settle();
        rd(`FCF_OFF_STATUS, 32'h0);
        results();
    end
endmodule : fcf_top_bench

`default_nettype wire
